// ===== hdl/pmr_irq_if.sv
// event and interrupt signals between the register core and the interrupt unit
`timescale 1ns/1ns
`default_nettype none
interface pmr_irq_if;
  logic [1:0] event_v;   // one-cycle event pulses
  logic       clr_wr;    // write-one-to-clear strobe
  logic       mask_wr;   // mask write strobe
  logic [1:0] wdata;     // write data for either strobe
  logic [1:0] status;    // sticky status
  logic [1:0] mask;      // mask
  logic       irq;       // registered interrupt level
  modport core (output event_v, clr_wr, mask_wr, wdata, input status, mask, irq);
  modport unit (input event_v, clr_wr, mask_wr, wdata, output status, mask, irq);
endinterface
`default_nettype wire

// ===== hdl/pmr_irq_unit.sv
// sticky event status, mask and interrupt level
`timescale 1ns/1ns
`default_nettype none
module pmr_irq_unit (
  input  wire logic   sys_clk_i,
  input  wire logic   rst_i,
  pmr_irq_if.unit     bus
);
  logic [1:0] status_reg;   // sticky events
  logic [1:0] status_next;
  logic [1:0] mask_reg;     // enables
  logic [1:0] mask_next;
  logic       irq_reg;      // level out
  logic       irq_next;

  // a new event beats a clear in the same cycle so nothing is lost
  always_comb begin
    status_next = status_reg & ~(bus.clr_wr ? bus.wdata : 2'h0);
    status_next = status_next | bus.event_v;
    mask_next   = bus.mask_wr ? bus.wdata : mask_reg;
    irq_next    = |(status_next & mask_next);
  end

  // registers only
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      status_reg <= 2'h0;
      mask_reg   <= 2'h0;
      irq_reg    <= 1'h0;
    end else begin
      status_reg <= status_next;
      mask_reg   <= mask_next;
      irq_reg    <= irq_next;
    end
  end

  assign bus.status = status_reg;
  assign bus.mask   = mask_reg;
  assign bus.irq    = irq_reg;

  set_wins_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    |bus.event_v |=> (status_reg & $past(bus.event_v)) == $past(bus.event_v))
    else $error("event lost against clear");
endmodule
`default_nettype wire

// ===== hdl/pmr_pkg.sv
// constants for the power-state and interrupt-message register bank
// Functional notes
// [RL1] two-bit power state, reset D0
// [RL2] D3hot to D0 write gives hot reset
// [RL3] read-only skip-internal-reset bit, reset one
// [RL4] read-only data value, loadable default
// [RL5] sticky power event enable bit
// [RL6] power event status always reads zero
// [RL7] bus power bits hardwired to zero
// [RL8] capability identifier reads 05h
// [RL9] next pointer reads 64h
// [RL10] message enable gates messages and INTx
// [RL11] 64-bit address capable reads one
// [RL12] writable dword-aligned message address
// [RL13] message registers on downstream ports only
// [RL14] upper address forms high address half
// [RL15] read-only and reserved bits ignore writes
// [RL16] multiple message enable writable, capable zero
package pmr_pkg;
  // register byte offsets
  localparam logic [7:0]  OFF_PM        = 8'h44;  // power state, extensions, data value
  localparam logic [7:0]  OFF_MSG_CTL   = 8'h4C;  // capability header and message control
  localparam logic [7:0]  OFF_MSG_ADDR  = 8'h50;  // message address low
  localparam logic [7:0]  OFF_MSG_UADDR = 8'h54;  // message address high
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'h80;  // sticky event status
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'h84;  // event mask
  // field positions
  localparam int          PS_LSB        = 0;
  localparam int          NSR_BIT       = 3;
  localparam int          PME_EN_BIT    = 8;
  localparam int          DSEL_LSB      = 9;
  localparam int          DSCALE_LSB    = 13;
  localparam int          PME_ST_BIT    = 15;
  localparam int          B2B3_BIT      = 22;
  localparam int          BPCC_BIT      = 23;
  localparam int          DVAL_LSB      = 24;
  localparam int          CAP_ID_LSB    = 0;
  localparam int          NEXT_PTR_LSB  = 8;
  localparam int          MSI_EN_BIT    = 16;
  localparam int          MMC_LSB       = 17;
  localparam int          MME_LSB       = 20;
  localparam int          A64_BIT       = 23;
  localparam int          MADDR_LSB     = 2;
  localparam int          EVT_W         = 2;
  localparam int          EVT_HOT_RST   = 0;      // d3hot exit with hot reset
  localparam int          EVT_PS_CHG    = 1;      // power state changed
  // encodings and reset values
  localparam logic [1:0]  PS_D0         = 2'h0;
  localparam logic [1:0]  PS_D3HOT      = 2'h3;
  localparam logic        NSR_RESET     = 1'h1;
  localparam logic [7:0]  DVAL_RESET    = 8'h00;
  localparam logic [3:0]  DSEL_RESET    = 4'h0;
  localparam logic [1:0]  DSCALE_VAL    = 2'h0;
  localparam logic [7:0]  CAP_ID_VAL    = 8'h05;
  localparam logic [7:0]  NEXT_PTR_VAL  = 8'h64;
  localparam logic [2:0]  MMC_VAL       = 3'h0;
  localparam logic [2:0]  MME_RESET     = 3'h0;
  localparam logic        A64_VAL       = 1'h1;
  localparam logic [29:0] MADDR_RESET   = 30'h00000000;
  localparam logic [31:0] MUADDR_RESET  = 32'h00000000;
  localparam logic [1:0]  STRAP_WAIT    = 2'h2;   // cycles before the strap is caught
  // strap capture sequence
  typedef enum logic [1:0] {PMR_WAIT, PMR_DONE} pmr_strap_t;
endpackage

// ===== hdl/pmr_regs.sv
// power-state and interrupt-message configuration registers of one port
`timescale 1ns/1ns
`default_nettype none
module pmr_regs (
  input  wire logic        sys_clk_i,            // core clock, 125 MHz
  input  wire logic        rst_i,                // synchronous, active high
  input  wire logic [7:0]  reg_addr_i,           // byte address
  input  wire logic [31:0] reg_wdata_i,          // write data
  input  wire logic        reg_wr_i,             // write strobe
  input  wire logic        reg_rd_i,             // read strobe
  output logic      [31:0] reg_rdata_o,          // read data, cycle after the strobe
  input  wire logic        downstream_strap_i,   // pin: high on a downstream port
  input  wire logic        autoload_valid_i,     // default reload from serial/eeprom
  input  wire logic        autoload_nsr_i,       // reloaded skip-internal-reset
  input  wire logic [7:0]  autoload_data_i,      // reloaded data value
  output logic      [1:0]  power_state_o,        // current power state
  output logic             pme_enable_o,         // power event message enable
  output logic      [3:0]  data_select_o,        // data select field
  output logic             hot_reset_o,          // one-cycle port hot reset
  output logic             internal_reset_o,     // one-cycle internal reset
  output logic             downstream_reset_out_n_o, // never pulled by the power path
  output logic             msi_enable_o,         // messages permitted
  output logic             intx_allowed_o,       // legacy pin interrupt allowed
  output logic      [2:0]  msi_mme_o,            // multiple message enable
  output logic      [63:0] msi_address_o,        // target of the message write
  output logic             irq_o                 // unmasked event pending
);
  ////////////////////////////////////////////////////////////////////////////
  // strap synchroniser and capture
  logic                ds_meta_reg;    // first stage, read only by the second
  logic                ds_sync_reg;    // second stage
  logic                is_ds_reg;      // caught strap
  logic                is_ds_next;
  pmr_pkg::pmr_strap_t strap_st_reg;   // capture sequence
  pmr_pkg::pmr_strap_t strap_st_next;
  logic [1:0]          strap_cnt_reg;  // wait for the synchroniser to fill
  logic [1:0]          strap_cnt_next;

  // two flops before anything looks at the pin
  always_ff @(posedge sys_clk_i) begin
    ds_meta_reg <= downstream_strap_i;
    ds_sync_reg <= ds_meta_reg;
  end

  // catch the strap once, after reset release and the sync delay
  always_comb begin
    strap_st_next  = strap_st_reg;
    strap_cnt_next = strap_cnt_reg;
    is_ds_next     = is_ds_reg;
    case (strap_st_reg)
      pmr_pkg::PMR_WAIT: begin
        if (strap_cnt_reg == pmr_pkg::STRAP_WAIT) begin
          is_ds_next    = ds_sync_reg;
          strap_st_next = pmr_pkg::PMR_DONE;
        end else begin
          strap_cnt_next = strap_cnt_reg + 2'h1;
        end
      end
      pmr_pkg::PMR_DONE: begin
        strap_st_next = pmr_pkg::PMR_DONE;
      end
      default: begin
        strap_st_next = pmr_pkg::PMR_WAIT;
      end
    endcase
  end

  // strap registers
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      strap_st_reg  <= pmr_pkg::PMR_WAIT;
      strap_cnt_reg <= 2'h0;
      is_ds_reg     <= 1'h0;
    end else begin
      strap_st_reg  <= strap_st_next;
      strap_cnt_reg <= strap_cnt_next;
      is_ds_reg     <= is_ds_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // field storage
  logic [1:0]  ps_reg;       // power state
  logic [1:0]  ps_next;
  logic        pme_en_reg;   // sticky: survives internal reset
  logic        pme_en_next;
  logic [3:0]  dsel_reg;     // data select
  logic [3:0]  dsel_next;
  logic        nsr_reg;      // skip-internal-reset, software read only
  logic        nsr_next;
  logic [7:0]  dval_reg;     // data value, software read only
  logic [7:0]  dval_next;
  logic        msi_en_reg;   // message enable
  logic        msi_en_next;
  logic        intx_reg;     // legacy interrupt allowed, its own flop
  logic        intx_next;
  logic [2:0]  mme_reg;      // multiple message enable
  logic [2:0]  mme_next;
  logic [29:0] maddr_reg;    // dword address
  logic [29:0] maddr_next;
  logic [31:0] muaddr_reg;   // upper address
  logic [31:0] muaddr_next;
  logic        hot_rst_reg;  // hot reset pulse
  logic        hot_rst_next;
  logic        int_rst_reg;  // internal reset pulse
  logic        int_rst_next;
  logic        wr_pm;        // decoded writes
  logic        wr_ctl;
  logic        wr_addr;
  logic        wr_uaddr;
  logic        d3_exit;      // d3hot to d0 write
  logic [1:0]  evt;          // event pulses

  pmr_irq_if irq_bus ();

  // message registers exist only on a downstream port
  always_comb begin
    wr_pm    = reg_wr_i && (reg_addr_i == pmr_pkg::OFF_PM);
    wr_ctl   = reg_wr_i && (reg_addr_i == pmr_pkg::OFF_MSG_CTL)   && is_ds_reg; // see [RL13]
    wr_addr  = reg_wr_i && (reg_addr_i == pmr_pkg::OFF_MSG_ADDR)  && is_ds_reg; // see [RL13]
    wr_uaddr = reg_wr_i && (reg_addr_i == pmr_pkg::OFF_MSG_UADDR) && is_ds_reg; // see [RL13]
    d3_exit  = wr_pm && (ps_reg == pmr_pkg::PS_D3HOT)
               && (reg_wdata_i[pmr_pkg::PS_LSB +: 2] == pmr_pkg::PS_D0); // see [RL2]
  end

  // writable fields take the write; read-only and reserved bits never do
  always_comb begin
    ps_next      = ps_reg;
    pme_en_next  = pme_en_reg;
    dsel_next    = dsel_reg;
    nsr_next     = nsr_reg;
    dval_next    = dval_reg;
    msi_en_next  = msi_en_reg;
    mme_next     = mme_reg;
    maddr_next   = maddr_reg;
    muaddr_next  = muaddr_reg;
    // hot reset on leaving d3hot; the downstream reset pin stays quiet
    hot_rst_next = d3_exit;                                   // see [RL2]
    // internal reset only while the skip bit is clear
    int_rst_next = d3_exit && !nsr_reg;                       // see [RL3]
    evt          = 2'h0;
    evt[pmr_pkg::EVT_HOT_RST] = d3_exit;
    evt[pmr_pkg::EVT_PS_CHG]  = wr_pm && (reg_wdata_i[pmr_pkg::PS_LSB +: 2] != ps_reg);
    // internal reset clears data select, message enable, multiple message enable and address; pme enable is kept
    if (int_rst_reg) begin
      dsel_next   = pmr_pkg::DSEL_RESET;
      msi_en_next = 1'h0;
      mme_next    = pmr_pkg::MME_RESET;
      maddr_next  = pmr_pkg::MADDR_RESET;
      muaddr_next = pmr_pkg::MUADDR_RESET;
    end
    // defaults reloaded by the serial port or eeprom
    if (autoload_valid_i) begin
      nsr_next  = autoload_nsr_i;                             // see [RL3]
      dval_next = autoload_data_i;                            // see [RL4]
    end
    if (wr_pm) begin
      ps_next     = reg_wdata_i[pmr_pkg::PS_LSB +: 2];        // see [RL1]
      pme_en_next = reg_wdata_i[pmr_pkg::PME_EN_BIT];         // see [RL5]
      dsel_next   = reg_wdata_i[pmr_pkg::DSEL_LSB +: 4];      // see [RL15]
    end
    if (wr_ctl) begin
      msi_en_next = reg_wdata_i[pmr_pkg::MSI_EN_BIT];         // see [RL10]
      mme_next    = reg_wdata_i[pmr_pkg::MME_LSB +: 3];       // see [RL16]
    end
    if (wr_addr) begin
      maddr_next = reg_wdata_i[31:pmr_pkg::MADDR_LSB];        // see [RL12]
    end
    if (wr_uaddr) begin
      muaddr_next = reg_wdata_i;                              // see [RL14]
    end
    // intx mirrors the enable from a flop so the pin never sees a gate glitch
    intx_next = !msi_en_next;                                 // see [RL10]
  end

  // field registers; pme enable is sticky and reset only by rst_i
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      ps_reg      <= pmr_pkg::PS_D0;                          // see [RL1]
      pme_en_reg  <= 1'h0;
      dsel_reg    <= pmr_pkg::DSEL_RESET;
      nsr_reg     <= pmr_pkg::NSR_RESET;
      dval_reg    <= pmr_pkg::DVAL_RESET;
      msi_en_reg  <= 1'h0;
      intx_reg    <= 1'h1;
      mme_reg     <= pmr_pkg::MME_RESET;
      maddr_reg   <= pmr_pkg::MADDR_RESET;
      muaddr_reg  <= pmr_pkg::MUADDR_RESET;
      hot_rst_reg <= 1'h0;
      int_rst_reg <= 1'h0;
    end else begin
      ps_reg      <= ps_next;
      pme_en_reg  <= pme_en_next;
      dsel_reg    <= dsel_next;
      nsr_reg     <= nsr_next;
      dval_reg    <= dval_next;
      msi_en_reg  <= msi_en_next;
      intx_reg    <= intx_next;
      mme_reg     <= mme_next;
      maddr_reg   <= maddr_next;
      muaddr_reg  <= muaddr_next;
      hot_rst_reg <= hot_rst_next;
      int_rst_reg <= int_rst_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt unit
  assign irq_bus.event_v = evt;
  assign irq_bus.clr_wr  = reg_wr_i && (reg_addr_i == pmr_pkg::OFF_IRQ_STAT);
  assign irq_bus.mask_wr = reg_wr_i && (reg_addr_i == pmr_pkg::OFF_IRQ_MASK);
  assign irq_bus.wdata   = reg_wdata_i[pmr_pkg::EVT_W-1:0];

  pmr_irq_unit u_irq (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .bus       (irq_bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] rd_mux;       // selected word
  logic [31:0] rdata_reg;    // answer, one cycle only
  logic [31:0] rdata_next;

  // unmapped and upstream-hidden words read as zero
  always_comb begin
    rd_mux = 32'h00000000;
    case (reg_addr_i)
      pmr_pkg::OFF_PM: begin
        rd_mux[pmr_pkg::PS_LSB +: 2]     = ps_reg;               // see [RL1]
        rd_mux[pmr_pkg::NSR_BIT]         = nsr_reg;              // see [RL3]
        rd_mux[pmr_pkg::PME_EN_BIT]      = pme_en_reg;           // see [RL5]
        rd_mux[pmr_pkg::DSEL_LSB +: 4]   = dsel_reg;
        rd_mux[pmr_pkg::DSCALE_LSB +: 2] = pmr_pkg::DSCALE_VAL;
        rd_mux[pmr_pkg::PME_ST_BIT]      = 1'h0;                 // see [RL6]
        rd_mux[pmr_pkg::B2B3_BIT]        = 1'h0;                 // see [RL7]
        rd_mux[pmr_pkg::BPCC_BIT]        = 1'h0;                 // see [RL7]
        rd_mux[pmr_pkg::DVAL_LSB +: 8]   = dval_reg;             // see [RL4]
      end
      pmr_pkg::OFF_MSG_CTL: begin
        if (is_ds_reg) begin                                     // see [RL13]
          rd_mux[pmr_pkg::CAP_ID_LSB +: 8]   = pmr_pkg::CAP_ID_VAL;   // see [RL8]
          rd_mux[pmr_pkg::NEXT_PTR_LSB +: 8] = pmr_pkg::NEXT_PTR_VAL; // see [RL9]
          rd_mux[pmr_pkg::MSI_EN_BIT]        = msi_en_reg;            // see [RL10]
          rd_mux[pmr_pkg::MMC_LSB +: 3]      = pmr_pkg::MMC_VAL;      // see [RL16]
          rd_mux[pmr_pkg::MME_LSB +: 3]      = mme_reg;               // see [RL16]
          rd_mux[pmr_pkg::A64_BIT]           = pmr_pkg::A64_VAL;      // see [RL11]
        end
      end
      pmr_pkg::OFF_MSG_ADDR: begin
        if (is_ds_reg) begin
          rd_mux[31:pmr_pkg::MADDR_LSB] = maddr_reg;             // see [RL12]
        end
      end
      pmr_pkg::OFF_MSG_UADDR: begin
        if (is_ds_reg) begin
          rd_mux = muaddr_reg;
        end
      end
      pmr_pkg::OFF_IRQ_STAT: begin
        rd_mux[pmr_pkg::EVT_W-1:0] = irq_bus.status;
      end
      pmr_pkg::OFF_IRQ_MASK: begin
        rd_mux[pmr_pkg::EVT_W-1:0] = irq_bus.mask;
      end
      default: begin
        rd_mux = 32'h00000000;
      end
    endcase
    rdata_next = reg_rd_i ? rd_mux : 32'h00000000;
  end

  // read data register
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h00000000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs, each from a flip-flop
  logic dsrst_n_reg;  // constant high: the power path never pulls the pin

  always_ff @(posedge sys_clk_i) begin
    dsrst_n_reg <= 1'h1;
  end

  assign reg_rdata_o              = rdata_reg;
  assign power_state_o            = ps_reg;
  assign pme_enable_o             = pme_en_reg;
  assign data_select_o            = dsel_reg;
  assign hot_reset_o              = hot_rst_reg;
  assign internal_reset_o         = int_rst_reg;
  assign downstream_reset_out_n_o = dsrst_n_reg;
  assign msi_enable_o             = msi_en_reg;
  assign intx_allowed_o           = intx_reg;
  assign msi_mme_o                = mme_reg;
  // the upper half only means something because 64-bit is advertised
  assign msi_address_o            = {muaddr_reg, maddr_reg, 2'h0};
  assign irq_o                    = irq_bus.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  ps_write_a: assert property (wr_pm |=> power_state_o == $past(reg_wdata_i[1:0])) // see [RL1]
    else $error("power state not written");
  hot_reset_a: assert property (d3_exit |=> hot_reset_o && downstream_reset_out_n_o) // see [RL2]
    else $error("d3hot exit without hot reset");
  no_hot_reset_a: assert property (hot_reset_o |-> $past(ps_reg) == pmr_pkg::PS_D3HOT) // see [RL2]
    else $error("hot reset without d3hot exit");
  int_reset_a: assert property (hot_reset_o |-> internal_reset_o == !$past(nsr_reg)) // see [RL3]
    else $error("internal reset against skip bit");
  pm_read_a: assert property (reg_rd_i && reg_addr_i == pmr_pkg::OFF_PM // see [RL6]
    |=> reg_rdata_o[15] == 1'h0 && reg_rdata_o[23:22] == 2'h0
        && reg_rdata_o[31:24] == $past(dval_reg))
    else $error("power word read wrong");
  cap_read_a: assert property (reg_rd_i && is_ds_reg // see [RL8]
    && reg_addr_i == pmr_pkg::OFF_MSG_CTL
    |=> reg_rdata_o[15:0] == 16'h6405 && reg_rdata_o[23] && reg_rdata_o[19:17] == 3'h0)
    else $error("capability header wrong");
  upstream_hide_a: assert property (reg_rd_i && !is_ds_reg // see [RL13]
    && reg_addr_i == pmr_pkg::OFF_MSG_ADDR |=> reg_rdata_o == 32'h00000000)
    else $error("message address visible upstream");
  addr_write_a: assert property (wr_addr |=> msi_address_o[31:0] // see [RL12]
    == {$past(reg_wdata_i[31:2]), 2'h0})
    else $error("message address not stored");
  intx_gate_a: assert property (intx_allowed_o == !msi_enable_o) // see [RL10]
    else $error("intx allowed while messages on");
  read_once_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h00000000) // see [RL15]
    else $error("read data held past its cycle");

  d3_exit_c: cover property (d3_exit ##1 internal_reset_o);
  msi_on_c: cover property (wr_ctl && reg_wdata_i[16]);
  irq_c: cover property (irq_o);
  // an upstream port reading a hidden word
  upstream_c: cover property (reg_rd_i && !is_ds_reg && reg_addr_i == pmr_pkg::OFF_MSG_ADDR);
endmodule
`default_nettype wire

// ===== tb/pm_msi_config_regs_tb_top.sv
// self-checking bench for the power-state and interrupt-message registers
`timescale 1ns/1ns
`default_nettype none
module pm_msi_config_regs_tb_top;
  logic        sys_clk_i = 1'b0; // core clock, 8 ns period
  logic        rst_i;            // synchronous reset
  logic [7:0]  addr;             // register address
  logic [31:0] wdata;            // write data
  logic        wr;               // write strobe
  logic        rd;               // read strobe
  logic        strap;            // high selects a downstream port
  logic        al_valid;         // autoload pulse
  logic        al_nsr;           // autoload skip bit
  logic [7:0]  al_data;          // autoload data value
  logic [31:0] rdata;            // read data
  logic [1:0]  ps;               // power state
  logic [3:0]  dsel;             // data select
  logic [2:0]  mme;              // multiple message enable
  logic [63:0] maddr;            // message target address
  logic        pme, hot, irst, dsrst_n, msi_en, intx, irq;
  int          err_count = 0;    // mismatches seen
  int          tests_run = 0;    // comparisons made
  integer      seed = 78127;     // fixed seed keeps runs repeatable
  logic [31:0] d, u;             // random stimulus words

  always #4 sys_clk_i = ~sys_clk_i;

  pmr_regs u_pmr_regs (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .downstream_strap_i(strap),
    .autoload_valid_i(al_valid), .autoload_nsr_i(al_nsr), .autoload_data_i(al_data),
    .power_state_o(ps), .pme_enable_o(pme), .data_select_o(dsel), .hot_reset_o(hot),
    .internal_reset_o(irst), .downstream_reset_out_n_o(dsrst_n), .msi_enable_o(msi_en),
    .intx_allowed_o(intx), .msi_mme_o(mme), .msi_address_o(maddr), .irq_o(irq));

  ////////////////////////////////////////////////////////////////////////////////
  // expected words, built from the field layout
  function automatic logic [31:0] exp_pm(input logic [31:0] v, input logic nsr,
                                         input logic [7:0] dv);
    return {dv, 8'h00, 3'h0, v[12:8], 4'h0, nsr, 1'b0, v[1:0]};
  endfunction
  function automatic logic [31:0] exp_ctl(input logic [31:0] v);
    return {8'h00, 1'b1, v[22:20], 3'h0, v[16], 8'h64, 8'h05};
  endfunction

  // compare a register read
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // compare port outputs, packed into one word
  task automatic chk_out(input logic [63:0] got, input logic [63:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // bus cycles: strobe for one cycle, return 1 ns after the sampling edge
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk_i);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    @(posedge sys_clk_i);
    wr    <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe, so look there
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk_i);
    addr <= a;
    rd   <= 1'b1;
    @(posedge sys_clk_i);
    rd   <= 1'b0;
    #1;
    chk_word(rdata, exp);
  endtask
  // irq is registered in the same cycle as status and mask, from their next values; two edges only give margin
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask
  // five reset cycles, then let the strap capture finish
  task automatic do_reset(input logic s);
    strap <= s;
    rst_i <= 1'b1;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the sequence needs well under 2000 cycles
  initial begin
    #160000;
    err_count++;
    summarize();
  end

  // main sequence
  initial begin
    addr <= 8'h00; wdata <= 32'h0; wr <= 1'b0; rd <= 1'b0;
    al_valid <= 1'b0; al_nsr <= 1'b0; al_data <= 8'h00;
    do_reset(1'b1);
    // reset values of the power and message words (not 80h or 84h) and of dsrst_n, intx, msi_en and ps
    rd_chk(8'h44, exp_pm(32'h0, 1'b1, 8'h00));
    rd_chk(8'h4C, exp_ctl(32'h0));
    rd_chk(8'h50, 32'h0);
    rd_chk(8'h54, 32'h0);
    chk_out({dsrst_n, intx, msi_en, ps}, {1'b1, 1'b1, 1'b0, 2'h0});
    // random message control and address traffic, first pass all ones except the upper address
    for (int i = 0; i < 12; i++) begin
      d = (i == 0) ? 32'hFFFFFFFF : $random(seed);
      u = $random(seed);
      wr_reg(8'h4C, d);
      wr_reg(8'h50, d);
      wr_reg(8'h54, u);
      rd_chk(8'h4C, exp_ctl(d));
      rd_chk(8'h50, d & 32'hFFFFFFFC);
      rd_chk(8'h54, u);
      chk_out({intx, msi_en, mme}, {~d[16], d[16], d[22:20]});
      chk_out(maddr, {u, d[31:2], 2'b00});
    end
    wr_reg(8'h4C, 32'h00010000);
    // all ones to the power word: fixed bits must hold
    wr_reg(8'h44, 32'hFFFFFFFF);
    rd_chk(8'h44, exp_pm(32'hFFFFFFFF, 1'b1, 8'h00));
    chk_out({pme, dsel, ps}, {1'b1, 4'hF, 2'h3});
    rd_chk(8'h80, 32'h2);
    // mask hides the pending bit, then lets it through, then clear
    wr_reg(8'h84, 32'h1);
    settle();
    chk_out({63'h0, irq}, 64'h0);
    wr_reg(8'h84, 32'h3);
    settle();
    chk_out({63'h0, irq}, 64'h1);
    wr_reg(8'h80, 32'h2);
    settle();
    chk_out({63'h0, irq}, 64'h0);
    // D3hot to D0 with skip bit set: hot reset only, pin untouched
    wr_reg(8'h44, 32'h00001F00);
    chk_out({hot, irst, dsrst_n}, 64'h5);
    @(posedge sys_clk_i);
    #1;
    chk_out({hot, irq, msi_en}, 64'h3);
    rd_chk(8'h80, 32'h3);
    wr_reg(8'h80, 32'h3);
    // autoload clears the skip bit and loads a random data value
    d = $random(seed);
    @(posedge sys_clk_i);
    al_valid <= 1'b1;
    al_nsr   <= 1'b0;
    al_data  <= d[7:0];
    @(posedge sys_clk_i);
    al_valid <= 1'b0;
    rd_chk(8'h44, exp_pm(32'h00001F00, 1'b0, d[7:0]));
    // D3hot to D0 again, now with internal reset; enable must survive
    wr_reg(8'h44, 32'h00001F03);
    wr_reg(8'h44, 32'h00001F00);
    chk_out({hot, irst, dsrst_n}, 64'h7);
    settle();
    chk_out({intx, msi_en, dsel, pme, ps}, {1'b1, 1'b0, 4'h0, 1'b1, 2'h0});
    // unmapped offset reads zero and keeps nothing
    wr_reg(8'h48, 32'hFFFFFFFF);
    rd_chk(8'h48, 32'h0);
    // upstream port: message registers absent, writes dropped
    do_reset(1'b0);
    wr_reg(8'h4C, 32'h00010000);
    wr_reg(8'h50, 32'hFFFFFFFC);
    wr_reg(8'h54, 32'hFFFFFFFF);
    rd_chk(8'h4C, 32'h0);
    rd_chk(8'h50, 32'h0);
    rd_chk(8'h54, 32'h0);
    chk_out({63'h0, msi_en}, 64'h0);
    chk_out(maddr, 64'h0);
    summarize();
  end
endmodule
`default_nettype wire
